// ==== rtl/shlt_regs.sv ====
`timescale 1ns/1ps
`include "shlt_defines.svh"
module shlt_regs #(
	parameter int MS_CYCLES = `SHLT_MS_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire shlt_pkg::shlt_addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire shlt_pkg::shlt_word_t avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output shlt_pkg::shlt_word_t avs_readdata,
	output logic avs_waitrequest,
	input wire logic hot_swap_en,
	input wire logic hotplug_strap,
	input wire logic [6:0] slot_events,
	output logic [15:0] slot_ctl,
	output logic [31:0] link_tune0,
	output logic [31:0] link_tune1,
	output logic [23:0] link_tune2,
	output logic [7:0] dbnc_field,
	output logic dbnc_tick,
	output logic [7:0] fts_symbol,
	output logic fts_is_k,
	output logic hp_capable,
	output logic irq
);
	import shlt_pkg::*;

	// ==========================================
	// bus slave: one wait cycle, then ack
	shlt_bus_st_t st_r;
	shlt_bus_st_t st_nxt;
	shlt_word_t rdata_r;
	logic [15:0] slot_ctl_r;
	logic [6:0] slot_stat_r;
	logic [31:0] tune0_r;
	logic [31:0] tune1_r;
	logic [23:0] tune2_r;
	logic [7:0] dbnc_r;
	logic hp_cap_r;
	logic strap_done_r;
	logic [`SHLT_NEVT-1:0] irq_stat_r;
	logic [`SHLT_NEVT-1:0] irq_en_r;

	wire req = avs_read | avs_write;
	wire ack = (st_r == SHLT_ACK);
	wire wr_ack = ack & avs_write;
	wire rd_ack = ack & avs_read;
	wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire sel_slot = (avs_address == `SHLT_OFS_SLOT);
	wire sel_t0 = (avs_address == `SHLT_OFS_TUNE0);
	wire sel_t1 = (avs_address == `SHLT_OFS_TUNE1);
	wire sel_t2 = (avs_address == `SHLT_OFS_TUNE2);
	wire sel_cap = (avs_address == `SHLT_OFS_CAP);
	wire sel_ist = (avs_address == `SHLT_OFS_IRQ_STAT);
	wire sel_ien = (avs_address == `SHLT_OFS_IRQ_EN);
	wire sel_icl = (avs_address == `SHLT_OFS_IRQ_CLR);
	wire sel_strap = (avs_address == `SHLT_OFS_STRAP);

	assign avs_waitrequest = req & ~ack;

	always_comb begin
		st_nxt = SHLT_IDLE;
		case (st_r)
			SHLT_IDLE: st_nxt = req ? SHLT_ACK : SHLT_IDLE;
			SHLT_ACK: st_nxt = SHLT_IDLE;
			default: st_nxt = SHLT_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r <= SHLT_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// write path, byte lanes honoured; reserved bits masked off
	wire [31:0] wd_t0 = (tune0_r & ~bmask) | (avs_writedata & bmask);
	wire [31:0] wd_t1 = (tune1_r & ~bmask) | (avs_writedata & bmask);
	wire [23:0] wd_t2 = (tune2_r & ~bmask[23:0]) | (avs_writedata[23:0] & bmask[23:0]);
	wire [15:0] wd_sc = (slot_ctl_r & ~bmask[15:0]) | (avs_writedata[15:0] & bmask[15:0]);
	wire dbnc_we = wr_ack & sel_t2 & avs_byteenable[3] & hot_swap_en;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			slot_ctl_r <= 16'h0000;
		end else if (wr_ack & sel_slot) begin
			slot_ctl_r <= wd_sc & `SHLT_SLOTCTL_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tune0_r <= `SHLT_TUNE0_RST;
		end else if (wr_ack & sel_t0) begin
			tune0_r <= wd_t0 & `SHLT_TUNE0_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tune1_r <= `SHLT_TUNE1_RST;
		end else if (wr_ack & sel_t1) begin
			tune1_r <= wd_t1 & `SHLT_TUNE1_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tune2_r <= `SHLT_TUNE2_RST;
		end else if (wr_ack & sel_t2) begin
			tune2_r <= wd_t2 & `SHLT_TUNE2_MASK;
		end
	end

	// top lane of the same word; silently dropped while hot swap is off
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dbnc_r <= 8'h00;
		end else if (dbnc_we) begin
			dbnc_r <= avs_writedata[31:24];
		end
	end

	// ==========================================
	// strap caught once after reset release, never under reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hp_cap_r <= 1'b0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			hp_cap_r <= hotplug_strap;
			strap_done_r <= 1'b1;
		end
	end

	// ==========================================
	// slot status: latched events, live states; set beats clear
	// events: 0 button, 1 fault, 2 latch chg, 3 presence chg, 4 cmd done
	wire [4:0] ev_in = slot_events[4:0];
	wire [4:0] ev_clr = (wr_ack & sel_icl) ? avs_writedata[4:0] : 5'h00;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			slot_stat_r <= 7'h00;
		end else begin
			slot_stat_r <= {slot_events[6:5], irq_stat_r | ev_in};
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_stat_r <= 5'h00;
		end else begin
			irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_in;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_en_r <= 5'h00;
		end else if (wr_ack & sel_ien) begin
			irq_en_r <= avs_writedata[4:0];
		end
	end

	// slot enables also gate the interrupt: bits 3:0 per event under master bit 5, bit 4 alone for event 4
	wire [4:0] slot_gate = {slot_ctl_r[4], slot_ctl_r[3:0] & {4{slot_ctl_r[5]}}};
	assign irq = |(irq_stat_r & irq_en_r & slot_gate);

	// ==========================================
	// debounce tick: (field+1) ms
	logic [17:0] ms_cnt_r;
	logic [7:0] ms_num_r;
	logic dbnc_tick_r;
	wire ms_wrap = (ms_cnt_r == 18'(MS_CYCLES - 1));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_r <= 18'h00000;
		end else begin
			ms_cnt_r <= ms_wrap ? 18'h00000 : ms_cnt_r + 18'h00001;
		end
	end

	// a smaller field written mid-count takes effect at the next millisecond
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ms_num_r <= 8'h00;
			dbnc_tick_r <= 1'b0;
		end else begin
			dbnc_tick_r <= 1'b0;
			if (ms_wrap) begin
				if (ms_num_r >= dbnc_r) begin
					ms_num_r <= 8'h00;
					dbnc_tick_r <= 1'b1;
				end else begin
					ms_num_r <= ms_num_r + 8'h01;
				end
			end
		end
	end

	// ==========================================
	// FTS symbol stream: one comma then three K28.1 per set
	logic [1:0] fts_pos_r;
	logic [7:0] fts_sym_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fts_pos_r <= 2'h0;
			fts_sym_r <= 8'hbc;
		end else begin
			fts_pos_r <= fts_pos_r + 2'h1;
			fts_sym_r <= (fts_pos_r == 2'h3) ? 8'hbc : 8'h3c;
		end
	end

	// ==========================================
	// read path
	wire [31:0] rd_slot = {9'h000, slot_stat_r, slot_ctl_r};
	wire [31:0] rd_t2 = {dbnc_r, tune2_r};
	wire [31:0] rd_cap = {16'h0000, `SHLT_CAP_NEXT, `SHLT_CAP_ID};
	wire [31:0] rd_mux =
		sel_slot ? rd_slot :
		sel_t0 ? tune0_r :
		sel_t1 ? tune1_r :
		sel_t2 ? rd_t2 :
		sel_cap ? rd_cap :
		sel_ist ? {27'h0, irq_stat_r} :
		sel_ien ? {27'h0, irq_en_r} :
		sel_strap ? {31'h0, hp_cap_r} :
		32'h0000_0000;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 32'h0000_0000;
		end else if (req & ~ack) begin
			rdata_r <= avs_read ? rd_mux : 32'h0000_0000;
		end
	end

	assign avs_readdata = rdata_r;
	assign slot_ctl = slot_ctl_r;
	assign link_tune0 = tune0_r;
	assign link_tune1 = tune1_r;
	assign link_tune2 = tune2_r;
	assign dbnc_field = dbnc_r;
	assign dbnc_tick = dbnc_tick_r;
	assign fts_symbol = fts_sym_r;
	assign fts_is_k = 1'b1;
	assign hp_capable = hp_cap_r;

	// ==========================================
	// checks
	// reset values, seen at the first edge after release
	a_tune0_reset: assert property (@(posedge mclk)
		$rose(rstn) |-> tune0_r == 32'h0400_1060)
		else $error("tuning zero reset value wrong");
	a_tune1_reset: assert property (@(posedge mclk)
		$rose(rstn) |-> tune1_r == 32'h0400_0217)
		else $error("tuning one reset value wrong");
	a_tune2_reset: assert property (@(posedge mclk)
		$rose(rstn) |-> tune2_r == 24'h19_0254)
		else $error("tuning two reset value wrong");
	a_slot_reset: assert property (@(posedge mclk)
		$rose(rstn) |-> slot_ctl_r == 16'h0000 && slot_stat_r == 7'h00)
		else $error("slot reset value wrong");
	a_dbnc_reset: assert property (@(posedge mclk)
		$rose(rstn) |-> dbnc_r == 8'h00)
		else $error("debounce reset value wrong");
	// slot control and status
	a_slot_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
		slot_ctl_r[15:11] == 5'h0)
		else $error("slot control reserved bits set");
	a_stat_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
		rd_ack && sel_slot |-> avs_readdata[31:23] == 9'h0)
		else $error("slot status reserved bits nonzero");
	a_slot_write: assert property (@(posedge mclk) disable iff (!rstn)
		wr_ack && sel_slot && avs_byteenable[1:0] == 2'h3
		|=> slot_ctl_r == (16'($past(avs_writedata)) & 16'h07ff))
		else $error("slot control write lost");
	a_slot_hold: assert property (@(posedge mclk) disable iff (!rstn)
		!(wr_ack && sel_slot) |=> $stable(slot_ctl_r))
		else $error("slot control changed without write");
	a_stat_set: assert property (@(posedge mclk) disable iff (!rstn)
		|ev_in |=> (irq_stat_r & $past(ev_in)) == $past(ev_in))
		else $error("slot event not latched");
	a_stat_clear: assert property (@(posedge mclk) disable iff (!rstn)
		wr_ack && sel_icl && ev_in == 5'h00 |=> (irq_stat_r & 5'($past(avs_writedata))) == 5'h00)
		else $error("event flag not cleared");
	a_irq_gate: assert property (@(posedge mclk) disable iff (!rstn)
		!slot_ctl_r[4] && !slot_ctl_r[5] |-> !irq)
		else $error("interrupt while slot enables off");
	// link tuning words
	a_tune0_write: assert property (@(posedge mclk) disable iff (!rstn)
		wr_ack && sel_t0 && avs_byteenable == 4'hf
		|=> tune0_r == ($past(avs_writedata) & 32'hffff_1fff))
		else $error("tuning zero write lost");
	a_tune0_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
		tune0_r[15:13] == 3'h0)
		else $error("tuning zero reserved bits set");
	a_tune0_hold: assert property (@(posedge mclk) disable iff (!rstn)
		!(wr_ack && sel_t0) |=> $stable(tune0_r))
		else $error("tuning zero changed without write");
	a_tune1_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
		tune1_r[15:10] == 6'h0)
		else $error("tuning one reserved bits set");
	a_tune1_write: assert property (@(posedge mclk) disable iff (!rstn)
		wr_ack && sel_t1 && avs_byteenable == 4'hf
		|=> tune1_r == ($past(avs_writedata) & 32'hffff_03ff))
		else $error("tuning one write lost");
	a_tune2_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
		!tune2_r[15] && !tune2_r[23])
		else $error("tuning two reserved bits set");
	a_tune2_write: assert property (@(posedge mclk) disable iff (!rstn)
		wr_ack && sel_t2 && avs_byteenable[2:0] == 3'h7
		|=> tune2_r == (24'($past(avs_writedata)) & 24'h7f_7fff))
		else $error("tuning two write lost");
	// debounce, capability header, fts, strap and bus
	a_dbnc_locked: assert property (@(posedge mclk) disable iff (!rstn)
		!hot_swap_en |=> $stable(dbnc_r))
		else $error("debounce changed while hot swap off");
	a_dbnc_write: assert property (@(posedge mclk) disable iff (!rstn)
		wr_ack && sel_t2 && avs_byteenable[3] && hot_swap_en
		|=> dbnc_r == 8'($past(avs_writedata) >> 24))
		else $error("debounce write lost");
	a_tick_align: assert property (@(posedge mclk) disable iff (!rstn)
		dbnc_tick_r |-> ms_cnt_r == 18'h00000)
		else $error("debounce tick off millisecond boundary");
	a_tick_pulse: assert property (@(posedge mclk) disable iff (!rstn)
		dbnc_tick_r |=> !dbnc_tick_r)
		else $error("debounce tick longer than one cycle");
	a_cap_read: assert property (@(posedge mclk) disable iff (!rstn)
		rd_ack && sel_cap |-> avs_readdata[7:0] == 8'h03)
		else $error("product_data_cap_id wrong");
	a_cap_next: assert property (@(posedge mclk) disable iff (!rstn)
		rd_ack && sel_cap |-> avs_readdata[15:8] == 8'hf0)
		else $error("next pointer wrong");
	a_fts_comma: assert property (@(posedge mclk) disable iff (!rstn)
		fts_sym_r == 8'hbc |=> fts_sym_r == 8'h3c ##1 fts_sym_r == 8'h3c
		##1 fts_sym_r == 8'h3c)
		else $error("fts set not comma plus three");
	a_fts_phase: assert property (@(posedge mclk) disable iff (!rstn)
		fts_pos_r == 2'h0 |-> fts_sym_r == 8'hbc)
		else $error("fts comma out of place");
	a_strap_copy: assert property (@(posedge mclk) disable iff (!rstn)
		strap_done_r && !$past(strap_done_r) |-> hp_cap_r == $past(hotplug_strap))
		else $error("hot-plug capability not taken from strap");
	a_strap_hold: assert property (@(posedge mclk) disable iff (!rstn)
		strap_done_r |=> $stable(hp_cap_r))
		else $error("hot-plug capability changed after reset");
	a_bus_ack: assert property (@(posedge mclk) disable iff (!rstn)
		req && !ack |=> !avs_waitrequest)
		else $error("bus answer late");
	c_write_t0: cover property (@(posedge mclk) wr_ack && sel_t0);
	c_read_cap: cover property (@(posedge mclk) rd_ack && sel_cap);
	c_irq: cover property (@(posedge mclk) $rose(irq));
	c_dbnc_wr: cover property (@(posedge mclk) dbnc_we);
	c_dbnc_tick: cover property (@(posedge mclk) dbnc_tick_r);
endmodule

// ==== rtl/shlt_defines.svh ====
`ifndef SHLT_DEFINES_SVH
`define SHLT_DEFINES_SVH
// ==========================================
// register byte offsets
`define SHLT_OFS_SLOT 8'hc8
`define SHLT_OFS_TUNE0 8'hcc
`define SHLT_OFS_TUNE1 8'hd0
`define SHLT_OFS_TUNE2 8'hd4
`define SHLT_OFS_CAP 8'hd8
`define SHLT_OFS_IRQ_STAT 8'he0
`define SHLT_OFS_IRQ_EN 8'he4
`define SHLT_OFS_IRQ_CLR 8'he8
`define SHLT_OFS_STRAP 8'hec
// ==========================================
// reset values and writable masks
`define SHLT_TUNE0_RST 32'h0400_1060
`define SHLT_TUNE0_MASK 32'hffff_1fff
`define SHLT_TUNE1_RST 32'h0400_0217
`define SHLT_TUNE1_MASK 32'hffff_03ff
`define SHLT_TUNE2_RST 24'h19_0254
`define SHLT_TUNE2_MASK 24'h7f_7fff
`define SHLT_SLOTCTL_MASK 16'h07ff
`define SHLT_CAP_ID 8'h03
`define SHLT_CAP_NEXT 8'hf0
// ==========================================
// fixed fields
`define SHLT_DBNC_LSB 24
`define SHLT_STAT_LSB 16
`define SHLT_MS_CYCLES 200000
`define SHLT_NEVT 5
`endif

// ==== rtl/shlt_pkg.sv ====
package shlt_pkg;
	typedef logic [7:0] shlt_addr_t;
	typedef logic [31:0] shlt_word_t;
	typedef enum logic [1:0] {
		SHLT_IDLE = 2'b01,
		SHLT_ACK = 2'b10
	} shlt_bus_st_t;
endpackage

// ==== verification/shlt_slot_model.sv ====
`timescale 1ns/1ps
// ==========================================
// slot side: button, fault, latch and presence sources
module shlt_slot_model (
	output logic [6:0] slot_events,
	input wire logic mclk
);
	initial slot_events = 7'h00;
	// one-cycle event pulse, launched just after an edge
	task automatic pulse(input int idx);
		@(posedge mclk);
		slot_events[idx] <= 1'b1;
		@(posedge mclk);
		slot_events[idx] <= 1'b0;
	endtask
	task automatic level(input logic latch, input logic pres);
		@(posedge mclk);
		slot_events[6:5] <= {pres, latch};
	endtask
endmodule

// ==== verification/test_slot_hotplug_link_tuning_regs.sv ====
`timescale 1ns/1ps
module test_slot_hotplug_link_tuning_regs;
	import shlt_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	shlt_addr_t avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	shlt_word_t avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic hot_swap_en = 1'b0;
	logic hotplug_strap = 1'b1;
	shlt_word_t avs_readdata, q;
	logic avs_waitrequest, dbnc_tick, fts_is_k, hp_capable, irq;
	logic [6:0] slot_events;
	logic [7:0] dbnc_field, fts_symbol;
	int errors = 0;
	int num_checks = 0;
	int t0;
	logic [7:0] dv;
	always #2.5 mclk = ~mclk;
	// short millisecond so the debounce run stays brief
	shlt_regs #(.MS_CYCLES(10)) DUT (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .hot_swap_en(hot_swap_en),
		.hotplug_strap(hotplug_strap), .slot_events(slot_events), .slot_ctl(),
		.link_tune0(), .link_tune1(), .link_tune2(), .dbnc_field(dbnc_field),
		.dbnc_tick(dbnc_tick), .fts_symbol(fts_symbol), .fts_is_k(fts_is_k),
		.hp_capable(hp_capable), .irq(irq));
	shlt_slot_model slot (.slot_events(slot_events), .mclk(mclk));
	task automatic chk(input shlt_word_t got, input shlt_word_t exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// request stands until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input shlt_addr_t a, input shlt_word_t d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input shlt_addr_t a, input shlt_word_t d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input shlt_addr_t a, input shlt_word_t m, input shlt_word_t e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rd(8'hc8, '1, 32'h0);
		rd(8'hcc, '1, 32'h0400_1060);
		rd(8'hd0, '1, 32'h0400_0217);
		rd(8'hd4, '1, 32'h0019_0254);
		rd(8'hd8, 32'hffff, 32'hf003);
		rd(8'hec, 32'h1, 32'h1);
		chk(32'(hp_capable), 32'h1);
		// all ones to 0xc8 through 0xd8: reserved and read-only bits must hold
		for (int a = 8'hc8; a <= 8'hd8; a += 4) wr(8'(a), '1);
		rd(8'hc8, '1, 32'h0000_07ff);
		rd(8'hcc, '1, 32'hffff_1fff);
		rd(8'hd0, '1, 32'hffff_03ff);
		rd(8'hd4, '1, 32'h007f_7fff);
		rd(8'hd8, 32'hffff, 32'hf003);
		rd(8'h40, '1, 32'h0);
		avs_byteenable <= 4'h1;
		wr(8'hcc, 32'h0);
		avs_byteenable <= 4'hf;
		rd(8'hcc, '1, 32'hffff_1f00);
		hot_swap_en <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			dv = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'hff;
			wr(8'hd4, {dv, 24'h0});
			rd(8'hd4, '1, {dv, 24'h0});
			chk(32'(dbnc_field), 32'(dv));
			@(posedge mclk iff dbnc_tick === 1'b1);
			t0 = 0;
			do begin
				@(posedge mclk);
				t0++;
			end while (dbnc_tick !== 1'b1);
			chk(32'(t0), (32'(dv) + 32'h1) * 32'd10);
		end
		wr(8'hc8, 32'h3f);
		wr(8'he4, 32'h1f);
		for (int i = 0; i < 5; i++) begin
			slot.pulse(i);
			rd(8'hc8, '1, 32'h3f | (32'h1 << (16 + i)));
			chk(32'(irq), 32'h1);
			wr(8'he8, 32'h1 << i);
			@(negedge mclk);
			chk(32'(irq), 32'h0);
		end
		slot.pulse(0);
		wr(8'hc8, 32'h0f);
		@(negedge mclk);
		chk(32'(irq), 32'h0);
		wr(8'he4, 32'h0);
		wr(8'hc8, 32'h3f);
		@(negedge mclk);
		chk(32'(irq), 32'h0);
		rd(8'he0, 32'h1f, 32'h1);
		slot.level(1'b1, 1'b1);
		rd(8'hc8, 32'h0060_0000, 32'h0060_0000);
		// second reset with the strap low: capability must follow it
		@(posedge mclk);
		rstn <= 1'b0;
		hotplug_strap <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		rd(8'hec, 32'h1, 32'h0);
		chk(32'(hp_capable), 32'h0);
		rd(8'hcc, '1, 32'h0400_1060);
		rd(8'hd4, '1, 32'h0019_0254);
		t0 = 0;
		while (fts_symbol !== 8'hbc && t0 < 8) begin
			@(negedge mclk);
			t0++;
		end
		repeat (3) begin
			@(negedge mclk);
			chk(32'(fts_symbol), 32'h3c);
		end
		chk(32'(fts_is_k), 32'h1);
		tally_and_finish();
	end
endmodule
